// >>> dv/fpe_flash_model.sv
`timescale 1ns/100ps
`include "fpe_cfg.svh"
module fpe_flash_model #(
    parameter logic [7:0] MAKER_CODE  = 8'h6C, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'h93  // Arbitrary value
) (
    input  wire logic        i_ce_n,                // Chip select
    input  wire logic        i_oe_n,                // Output enable
    input  wire logic        i_we_n,                // Write strobe
    input  wire logic        i_program_supply_high, // Supply high
    input  wire logic [16:0] i_addr,                // Address pins
    input  wire logic [7:0]  i_dq,                  // Data from host
    output wire logic [7:0]  o_dq                   // Data to host
);
    logic [7:0]  mem [0:15] = '{default: 8'hFF};
    logic [7:0]  cmd = `FPE_CMD_READ;
    logic [7:0]  pd;
    logic [7:0]  held = 8'h00;
    logic [16:0] wa;
    logic [16:0] pa;
    logic [16:0] va;
    logic        data_next = 0;
    logic        programming = 0;
    logic        erasing = 0;
    wire         rd_on = !i_ce_n && !i_oe_n && i_we_n;
    // Address taken at strobe fall
    always @(negedge i_we_n) if (!i_ce_n) wa = i_addr;
    // Command or data taken at strobe rise; a rise with chip select low and supply high ends a pulse
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_program_supply_high) begin
            if (programming) mem[pa[3:0]] = mem[pa[3:0]] & pd;
            if (erasing) mem = '{default: 8'hFF};
            programming = 0;
            erasing = 0;
            if (data_next) begin
                pa = wa;
                pd = i_dq;
                programming = 1;
                data_next = 0;
            end else begin
                erasing = (cmd == `FPE_CMD_ERASE && i_dq == `FPE_CMD_ERASE);
                data_next = (i_dq == `FPE_CMD_PROG);
                if (i_dq == `FPE_CMD_ERASE_VFY) va = wa;
                if (i_dq == `FPE_CMD_PROG_VFY) va = pa;
                cmd = (cmd == `FPE_CMD_RESET && i_dq == `FPE_CMD_RESET) ? `FPE_CMD_READ : i_dq;
            end
        end
    end
    // Read source by mode
    wire [7:0] rd_val = (cmd == `FPE_CMD_SIG) ? (i_addr[0] ? DEVICE_CODE : MAKER_CODE)
        : (cmd == `FPE_CMD_ERASE_VFY || cmd == `FPE_CMD_PROG_VFY) ? mem[va[3:0]] : mem[i_addr[3:0]];
    // Released bus shows the inverse of the last value
    always @* if (rd_on) held = rd_val;
    assign o_dq = rd_on ? rd_val : ~held;
endmodule

// >>> dv/fpe_host_properties.sv
`timescale 1ns/100ps
`include "fpe_cfg.svh"
module fpe_host_properties
    import fpe_pkg::*;
(
    input wire logic       i_core_clk,            // Clock
    input wire logic       i_rst,                 // Sync reset
    input wire logic       i_req,                 // Start request
    input wire fpe_op_type i_op,                  // Operation kind
    input wire logic       o_busy,                // Busy level
    input wire logic       o_done,                // Done pulse
    input wire logic       o_ce_n,                // Chip select
    input wire logic       o_oe_n,                // Output enable
    input wire logic       o_we_n,                // Write strobe
    input wire logic       o_program_supply_high, // Supply switch
    input wire logic [7:0] o_dq_out,              // Data pins out
    input wire logic       o_dq_oe                // Data drive enable
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // One write cycle carrying a code
    sequence s_wr(logic [7:0] code);
        $fell(o_we_n) && o_dq_out == code;
    endsequence
    // Request taken for an operation
    sequence s_go(fpe_op_type op);
        i_req && !o_busy && i_op == op;
    endsequence
    a_write_strobe_ok: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe && o_program_supply_high)
        else $error("write strobe without select, drive or supply");
    a_write_one_cycle: assert property ($fell(o_we_n) |=> !o_we_n ##1 (o_we_n && !o_ce_n) ##1 !o_ce_n ##1 o_ce_n)
        else $error("write strobe or select held wrong length");
    a_read_strobe_ok: assert property (!o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe)
        else $error("read strobe with write or drive active");
    a_idle_bus_quiet: assert property (!o_busy && !o_done |-> o_ce_n && o_we_n && o_oe_n && !o_dq_oe)
        else $error("strobes active while idle");
    a_erase_code_twice: assert property (s_go(FPE_OP_ERASE) |-> ##[1:8] s_wr(8'h20) ##[1:8] s_wr(8'h20))
        else $error("erase not started by two erase codes");
    a_erase_then_verify: assert property (s_wr(8'h20) ##[1:8] s_wr(8'h20) |-> ##[1:1000] s_wr(8'hA0))
        else $error("erase pulse not ended by verify code");
    a_prog_then_verify: assert property (s_wr(8'h40) ##[1:8] $fell(o_we_n) |-> ##[1:300] s_wr(8'hC0))
        else $error("program data not followed by verify code");
    a_abort_code_pair: assert property (s_go(FPE_OP_ABORT) |-> ##[1:8] s_wr(8'hFF) ##[1:8] s_wr(8'hFF))
        else $error("abort not sent as two reset codes");
    a_done_one_pulse: assert property (o_done |=> !o_done && !o_busy)
        else $error("done longer than one cycle");
endmodule

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    import fpe_pkg::*;
    localparam logic [7:0] MAKER  = 8'h6C; // Arbitrary value
    localparam logic [7:0] DEVICE = 8'h93; // Arbitrary value
    logic        i_core_clk = 0;
    logic        i_rst = 1;
    logic        i_req = 0;
    fpe_op_type  i_op = FPE_OP_READ;
    logic [16:0] i_addr = '0;
    logic [7:0]  i_wdata = '0;
    wire  [7:0]  i_dq_in, o_rdata, o_dq_out;
    wire  [16:0] o_addr;
    wire         o_busy, o_done, o_fail, o_ce_n, o_oe_n, o_we_n, o_program_supply_high, o_dq_oe;
    int          n_mismatch = 0;
    int          tests_run = 0;
    fpe_host #(.ERASE_CYC(50), .LAST_ADDR(3)) DUT (.i_core_clk, .i_rst, .i_req, .i_op, .i_addr, .i_wdata,
        .i_dq_in, .o_busy, .o_done, .o_fail, .o_rdata, .o_ce_n, .o_oe_n, .o_we_n, .o_program_supply_high,
        .o_addr, .o_dq_out, .o_dq_oe);
    fpe_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) FLASH (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n),
        .i_we_n(o_we_n), .i_program_supply_high(o_program_supply_high), .i_addr(o_addr), .i_dq(o_dq_out),
        .o_dq(i_dq_in));
    initial forever #50 i_core_clk = ~i_core_clk;
    // Comparisons
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    // One request, then wait for done
    task automatic run_op(input fpe_op_type op, input logic [16:0] a, input logic [7:0] d);
        int n;
        @(negedge i_core_clk);
        i_op = op;
        i_addr = a;
        i_wdata = d;
        i_req = 1;
        @(negedge i_core_clk);
        i_req = 0;
        n = 0;
        while (o_done !== 1'b1 && n < 20000) begin
            @(negedge i_core_clk);
            n++;
        end
        chk_flag(o_done, 1'b1, "done");
    endtask
    task automatic t_read();
        FLASH.mem[5] = 8'h3C;
        run_op(FPE_OP_READ, 17'h5, 8'h00);
        chk_byte(o_rdata, 8'h3C, "read data");
        $display("test read finished");
    endtask
    task automatic t_sig();
        run_op(FPE_OP_SIG, 17'h0, 8'h00);
        chk_byte(o_rdata, MAKER, "maker code");
        run_op(FPE_OP_SIG, 17'h1, 8'h00);
        chk_byte(o_rdata, DEVICE, "device code");
        $display("test signature finished");
    endtask
    task automatic t_program();
        run_op(FPE_OP_PROGRAM, 17'h2, 8'hA5);
        chk_flag(o_fail, 1'b0, "program fail flag");
        chk_byte(FLASH.mem[2], 8'hA5, "programmed byte");
        run_op(FPE_OP_PROGRAM, 17'h3, 8'h0F);
        chk_byte(FLASH.mem[3], 8'h0F, "second byte");
        run_op(FPE_OP_READ, 17'h2, 8'h00);
        chk_byte(o_rdata, 8'hA5, "read back");
        $display("test program finished");
    endtask
    task automatic t_prog_fail();
        FLASH.mem[6] = 8'h00;
        run_op(FPE_OP_PROGRAM, 17'h6, 8'h0F);
        chk_flag(o_fail, 1'b1, "retry limit flag");
        chk_byte(FLASH.cmd, 8'h00, "read mode after failure");
        $display("test program failure finished");
    endtask
    task automatic t_erase();
        FLASH.mem[0] = 8'h00;
        FLASH.mem[1] = 8'h12;
        run_op(FPE_OP_ERASE, 17'h0, 8'h00);
        chk_flag(o_fail, 1'b0, "erase fail flag");
        for (int a = 0; a < 4; a++) chk_byte(FLASH.mem[a], 8'hFF, "erased byte");
        $display("test erase finished");
    endtask
    task automatic t_abort();
        FLASH.cmd = 8'h90;
        run_op(FPE_OP_ABORT, 17'h0, 8'h00);
        chk_byte(FLASH.cmd, 8'h00, "mode after abort");
        $display("test abort finished");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(negedge i_core_clk);
        i_rst = 0;
        t_read();
        t_sig();
        t_program();
        t_prog_fail();
        t_erase();
        t_abort();
        tally_and_finish();
    end
    // Watchdog
    initial begin
        repeat (30000) @(posedge i_core_clk);
        n_mismatch++;
        $display("ERROR %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
bind fpe_host fpe_host_properties u_chk (.i_core_clk, .i_rst, .i_req, .i_op, .o_busy, .o_done, .o_ce_n,
    .o_oe_n, .o_we_n, .o_program_supply_high, .o_dq_out, .o_dq_oe);

// >>> rtl/fpe_cfg.svh
`ifndef FPE_CFG_SVH
`define FPE_CFG_SVH
// Command codes written to the flash command register
`define FPE_CMD_READ      8'h00
`define FPE_CMD_SIG       8'h90
`define FPE_CMD_ERASE     8'h20
`define FPE_CMD_ERASE_VFY 8'hA0
`define FPE_CMD_PROG      8'h40
`define FPE_CMD_PROG_VFY  8'hC0
`define FPE_CMD_RESET     8'hFF
// Signature addresses
`define FPE_SIG_MAKER_ADDR  17'h00000
`define FPE_SIG_DEVICE_ADDR 17'h00001
// Bus phase timing, in ns, and cycle counts at 10 MHz
`define FPE_CLK_NS        100
`define FPE_WE_LOW_NS     100
`define FPE_WE_HIGH_NS    100
`define FPE_READ_NS       200
`define FPE_PROG_PULSE_NS 10000
`define FPE_PROG_REC_NS   6000
`define FPE_ERASE_PULSE_NS 10000000
`define FPE_CYC(ns) (((ns) + `FPE_CLK_NS - 1) / `FPE_CLK_NS)
// Retry limits
`define FPE_PROG_RETRIES  25
`define FPE_ERASE_RETRIES 1000
`endif

// >>> rtl/fpe_host.sv
`timescale 1ns/100ps
`include "fpe_cfg.svh"
module fpe_host #(
    parameter int ADDR_W        = 17,
    parameter int DATA_W        = 8,
    parameter int PROG_RETRIES  = `FPE_PROG_RETRIES,
    parameter int ERASE_RETRIES = `FPE_ERASE_RETRIES,
    parameter int ERASE_CYC     = `FPE_CYC(`FPE_ERASE_PULSE_NS),
    parameter int LAST_ADDR     = (1 << 17) - 1
) (
    input  wire logic                i_core_clk,  // 10 MHz clock
    input  wire logic                i_rst,       // Sync reset, high
    input  wire logic                i_req,       // Start operation pulse
    input  wire fpe_pkg::fpe_op_type i_op,        // Operation kind
    input  wire logic [ADDR_W-1:0]   i_addr,      // Target address
    input  wire logic [DATA_W-1:0]   i_wdata,     // Program data
    input  wire logic [DATA_W-1:0]   i_dq_in,     // Flash data pins in
    output logic                     o_busy,      // Operation running
    output logic                     o_done,      // Completion pulse
    output logic                     o_fail,      // Retry limit hit
    output logic [DATA_W-1:0]        o_rdata,     // Read result
    output logic                     o_ce_n,      // Flash chip select
    output logic                     o_oe_n,      // Flash output enable
    output logic                     o_we_n,      // Flash write strobe
    output logic                     o_program_supply_high, // Supply switch
    output logic [ADDR_W-1:0]        o_addr,      // Flash address pins
    output logic [DATA_W-1:0]        o_dq_out,    // Flash data pins out
    output logic                     o_dq_oe      // Data pin drive enable
);
    import fpe_pkg::*;

    localparam int WL_CYC  = `FPE_CYC(`FPE_WE_LOW_NS);
    localparam int WH_CYC  = `FPE_CYC(`FPE_WE_HIGH_NS);
    localparam int RD_CYC  = `FPE_CYC(`FPE_READ_NS);
    localparam int PP_CYC  = `FPE_CYC(`FPE_PROG_PULSE_NS);
    localparam int REC_CYC = `FPE_CYC(`FPE_PROG_REC_NS);
    // Counter must hold the longest wait, erase or program pulse
    localparam int CNT_MAX = (ERASE_CYC > PP_CYC) ? ERASE_CYC : PP_CYC;
    localparam int CNT_W   = $clog2(CNT_MAX + 2);

    // Step of a sequence: which bus cycle comes next
    typedef enum logic [2:0] {
        FPE_SP_CMD1 = 3'b000,
        FPE_SP_CMD2 = 3'b001,
        FPE_SP_VCMD = 3'b010,
        FPE_SP_VRD  = 3'b011,
        FPE_SP_EXIT = 3'b100
    } fpe_step_type;

    fpe_state_type     state_ff;
    fpe_step_type      step_ff;
    fpe_op_type        op_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic [15:0]       try_ff;
    logic [ADDR_W-1:0] tgt_ff;
    logic [DATA_W-1:0] wd_ff;
    logic [DATA_W-1:0] cmd_ff;
    logic              is_read_ff;
    logic              cnt_zero;
    logic              match;
    logic [DATA_W-1:0] expect_val;
    logic              last_addr;
    logic              retry_over;

    // Comparison of verify data and retry limit
    assign cnt_zero   = (cnt_ff == '0);
    assign expect_val = (op_ff == FPE_OP_ERASE) ? 8'hFF : wd_ff;
    // Compare the captured byte; the data pins are released by now
    assign match      = (o_rdata == expect_val);
    assign last_addr  = (tgt_ff == ADDR_W'(LAST_ADDR));
    assign retry_over = (op_ff == FPE_OP_ERASE) ? (try_ff >= 16'(ERASE_RETRIES))
                                                : (try_ff >= 16'(PROG_RETRIES));

    // Command for a first write cycle of an operation
    function automatic logic [7:0] first_cmd(input fpe_op_type op);
        case (op)
            FPE_OP_SIG:     first_cmd = `FPE_CMD_SIG;
            FPE_OP_PROGRAM: first_cmd = `FPE_CMD_PROG;
            FPE_OP_ERASE:   first_cmd = `FPE_CMD_ERASE;
            FPE_OP_ABORT:   first_cmd = `FPE_CMD_RESET;
            default:        first_cmd = `FPE_CMD_READ;
        endcase
    endfunction

    // Sequencer: write cycles, read cycles, pulse waits, verify loop
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_ff   <= FPE_ST_IDLE;
            step_ff    <= FPE_SP_CMD1;
            op_ff      <= FPE_OP_READ;
            cnt_ff     <= '0;
            try_ff     <= 16'h0000;
            tgt_ff     <= '0;
            wd_ff      <= 8'h00;
            cmd_ff     <= 8'h00;
            is_read_ff <= 1'b0;
            o_busy     <= 1'b0;
            o_done     <= 1'b0;
            o_fail     <= 1'b0;
            o_rdata    <= 8'h00;
            o_ce_n     <= 1'b1;
            o_oe_n     <= 1'b1;
            o_we_n     <= 1'b1;
            o_program_supply_high <= 1'b0;
            o_addr     <= '0;
            o_dq_out   <= 8'h00;
            o_dq_oe    <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (!cnt_zero) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
            case (state_ff)
                FPE_ST_IDLE: begin
                    if (i_req) begin
                        op_ff    <= i_op;
                        tgt_ff   <= (i_op == FPE_OP_ERASE) ? '0 : i_addr;
                        wd_ff    <= i_wdata;
                        try_ff   <= 16'h0000;
                        o_fail   <= 1'b0;
                        o_busy   <= 1'b1;
                        o_program_supply_high <= 1'b1;
                        cmd_ff   <= first_cmd(i_op);
                        step_ff  <= FPE_SP_CMD1;
                        state_ff <= FPE_ST_WLOW;
                        cnt_ff   <= CNT_W'(WH_CYC);
                    end
                end
                FPE_ST_WLOW: begin
                    // Write cycle: supply settles, then strobe low for WL_CYC + 1 cycles
                    if (cnt_zero && o_we_n) begin
                        o_ce_n   <= 1'b0;
                        o_we_n   <= 1'b0;
                        o_dq_oe  <= 1'b1;
                        o_dq_out <= cmd_ff;
                        // Address presented on falling strobe edge
                        o_addr   <= (op_ff == FPE_OP_PROGRAM && step_ff == FPE_SP_CMD2) ||
                                    (step_ff == FPE_SP_VCMD && op_ff == FPE_OP_ERASE) ? tgt_ff : '0;
                        cnt_ff   <= CNT_W'(WL_CYC);
                    end else if (cnt_zero) begin
                        o_we_n   <= 1'b1;
                        cnt_ff   <= CNT_W'(WH_CYC);
                        state_ff <= FPE_ST_WHIGH;
                    end
                end
                FPE_ST_WHIGH: begin
                    if (cnt_zero) begin
                        o_ce_n  <= 1'b1;
                        o_dq_oe <= 1'b0;
                        state_ff <= FPE_ST_WAIT;
                        case (step_ff)
                            FPE_SP_CMD1: begin
                                if (op_ff == FPE_OP_READ || op_ff == FPE_OP_SIG) begin
                                    is_read_ff <= 1'b1;
                                    state_ff   <= FPE_ST_RLOW;
                                end else begin
                                    // Second identical erase/reset code, or program data
                                    cmd_ff   <= (op_ff == FPE_OP_PROGRAM) ? wd_ff : cmd_ff;
                                    step_ff  <= FPE_SP_CMD2;
                                    state_ff <= FPE_ST_WLOW;
                                end
                            end
                            FPE_SP_CMD2: begin
                                if (op_ff == FPE_OP_ABORT) begin
                                    state_ff <= FPE_ST_DONE;
                                end else begin
                                    // Pulse runs; the verify write after ERASE_CYC or PP_CYC ends it
                                    cnt_ff  <= (op_ff == FPE_OP_ERASE) ? CNT_W'(ERASE_CYC)
                                                                       : CNT_W'(PP_CYC);
                                    step_ff <= FPE_SP_VCMD;
                                    cmd_ff  <= (op_ff == FPE_OP_ERASE) ? `FPE_CMD_ERASE_VFY
                                                                       : `FPE_CMD_PROG_VFY;
                                end
                            end
                            FPE_SP_VCMD: begin
                                cnt_ff   <= CNT_W'(REC_CYC);
                                step_ff  <= FPE_SP_VRD;
                            end
                            default: begin
                                state_ff <= FPE_ST_DONE;
                            end
                        endcase
                    end
                end
                FPE_ST_WAIT: begin
                    if (cnt_zero) begin
                        if (step_ff == FPE_SP_VRD) begin
                            is_read_ff <= 1'b0;
                            state_ff   <= FPE_ST_RLOW;
                        end else begin
                            // Verify write ends pulse; program verify drives address 0, erase verify the target
                            state_ff <= FPE_ST_WLOW;
                        end
                    end
                end
                FPE_ST_RLOW: begin
                    // Read cycle: chip select and output enable low, strobe high
                    if (o_oe_n) begin
                        o_ce_n <= 1'b0;
                        o_oe_n <= 1'b0;
                        o_addr <= (is_read_ff) ? tgt_ff : '0;
                        cnt_ff <= CNT_W'(RD_CYC);
                    end else if (cnt_zero) begin
                        o_ce_n   <= 1'b1;
                        o_oe_n   <= 1'b1;
                        o_rdata  <= i_dq_in;
                        state_ff <= is_read_ff ? FPE_ST_DONE : FPE_ST_CHECK;
                    end
                end
                FPE_ST_CHECK: begin
                    step_ff  <= FPE_SP_CMD1;
                    state_ff <= FPE_ST_WLOW;
                    if (match && op_ff == FPE_OP_ERASE && !last_addr) begin
                        // Next byte verified without a new pulse
                        tgt_ff  <= tgt_ff + 1'b1;
                        cmd_ff  <= `FPE_CMD_ERASE_VFY;
                        step_ff <= FPE_SP_VCMD;
                    end else if (match || retry_over) begin
                        o_fail  <= !match;
                        op_ff   <= FPE_OP_READ;
                        cmd_ff  <= `FPE_CMD_READ;
                        step_ff <= FPE_SP_EXIT;
                    end else begin
                        try_ff  <= try_ff + 16'h0001;
                        cmd_ff  <= first_cmd(op_ff);
                    end
                end
                FPE_ST_DONE: begin
                    o_busy   <= 1'b0;
                    o_done   <= 1'b1;
                    o_program_supply_high <= 1'b0;
                    state_ff <= FPE_ST_IDLE;
                end
                default: begin
                    state_ff <= FPE_ST_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> rtl/fpe_pkg.sv
package fpe_pkg;
    // Host operation requested by the user side
    typedef enum logic [2:0] {
        FPE_OP_READ    = 3'b000,
        FPE_OP_SIG     = 3'b001,
        FPE_OP_PROGRAM = 3'b010,
        FPE_OP_ERASE   = 3'b011,
        FPE_OP_ABORT   = 3'b100
    } fpe_op_type;
    // Controller states
    typedef enum logic [3:0] {
        FPE_ST_IDLE   = 4'b0000,
        FPE_ST_WLOW   = 4'b0001,
        FPE_ST_WHIGH  = 4'b0010,
        FPE_ST_WAIT   = 4'b0011,
        FPE_ST_RLOW   = 4'b0100,
        FPE_ST_CHECK  = 4'b0101,
        FPE_ST_DONE   = 4'b0110
    } fpe_state_type;
endpackage
